// *** core/vmac_pkg.sv ***
// Purpose: Constants, types and helpers for the configuration register bank.
// Assumes: Byte addresses of dword registers in a 4 KB configuration space.
// Notes: Summary of the behaviour is listed below; tags mark the code.
//
// Summary of operation
// (RULE1) Data window mirrors EEPROM at address plus 40h.
// (RULE2) Low byte lane is the byte at address.
// (RULE3) Data window honours configuration byte enables.
// (RULE4) Operation bit: 0 reads then sets, 1 writes.
// (RULE5) Range E0h to ECh is reserved, reads zero.
// (RULE6) Interrupt capability at F0h, identifier 05h.
// (RULE7) Interrupt capability next pointer reads 00h.
// (RULE8) Enable 0 uses INTx pins, 1 ignores them.
// (RULE9) Requested message count read-only, resets 000.
// (RULE10) Host programs allocated count without reserved codes.
// (RULE11) Message address keeps bits 31:2, low zero.
// (RULE12) Upper message address at F8h fully writable.
// (RULE13) Message data 16 bits, upper half zero.
// (RULE14) Error capability at 100h, identifier 0001h.
// (RULE15) Error capability version 1h in 19:16.
// (RULE16) Error capability next offset reads 150h.
// (RULE17) Uncorrectable status flags sticky, write-one-to-clear.
// (RULE18) Uncorrectable mask at 108h, sticky read/write.
// (RULE19) Mask records flag but suppresses report, first-error.
// (RULE20) Sticky bits survive hot reset, cleared at power-on.

package vmac_pkg;

	localparam int unsigned ADDR_W      = 12;
	localparam int unsigned UNC_W       = 21;
	localparam int unsigned FIRST_PTR_W = 5;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] OFS_VPD_CTRL    = 12'h0D8;
	localparam logic [ADDR_W-1:0] OFS_PRODUCT_DATA_WINDOW    = 12'h0DC;
	localparam logic [ADDR_W-1:0] OFS_RSVD_FIRST  = 12'h0E0;
	localparam logic [ADDR_W-1:0] OFS_RSVD_LAST   = 12'h0EC;
	localparam logic [ADDR_W-1:0] OFS_MSI_CTRL    = 12'h0F0;
	localparam logic [ADDR_W-1:0] OFS_MSI_ADDR_LO = 12'h0F4;
	localparam logic [ADDR_W-1:0] OFS_MSI_ADDR_HI = 12'h0F8;
	localparam logic [ADDR_W-1:0] OFS_MSI_DATA    = 12'h0FC;
	localparam logic [ADDR_W-1:0] OFS_AER_HDR     = 12'h100;
	localparam logic [ADDR_W-1:0] OFS_UNC_STATUS  = 12'h104;
	localparam logic [ADDR_W-1:0] OFS_UNC_MASK    = 12'h108;

	// Product data control word fields.
	localparam logic [7:0]  VPD_CAP_ID       = 8'h03;
	localparam logic [7:0]  VPD_NEXT_PTR     = 8'hF0;
	localparam int unsigned VPD_ADDR_LSB     = 18;
	localparam int unsigned VPD_ADDR_W       = 6;
	localparam int unsigned VPD_OP_BIT       = 31;
	localparam logic [7:0]  VPD_EEPROM_BASE  = 8'h40;

	// Message interrupt capability fields.
	localparam logic [7:0]  MSI_CAP_ID       = 8'h05;
	localparam logic [7:0]  MSI_NEXT_PTR     = 8'h00;
	localparam int unsigned MSI_EN_BIT       = 16;
	localparam int unsigned MSI_MMC_LSB      = 17;
	localparam int unsigned MSI_MME_LSB      = 20;
	localparam int unsigned MSI_A64_BIT      = 23;
	localparam logic [2:0]  MSI_MMC_VALUE    = 3'h0;
	localparam logic [2:0]  MSI_MME_RESET    = 3'h0;
	localparam logic        MSI_A64_RESET    = 1'b1;
	localparam logic [31:0] MSI_ADDR_WMASK   = 32'hFFFF_FFFC;
	localparam logic [31:0] MSI_DATA_WMASK   = 32'h0000_FFFF;

	// Error reporting capability header fields.
	localparam logic [15:0] AER_CAP_ID       = 16'h0001;
	localparam logic [3:0]  AER_VERSION      = 4'h1;
	localparam logic [11:0] AER_NEXT_OFS     = 12'h150;

	// Uncorrectable error flag positions.
	localparam int unsigned UNC_TRAINING     = 0;
	localparam int unsigned UNC_LINK_PROT    = 4;
	localparam int unsigned UNC_POISONED     = 12;
	localparam int unsigned UNC_FLOW_CTRL    = 13;
	localparam int unsigned UNC_CPL_TIMEOUT  = 14;
	localparam int unsigned UNC_CPL_ABORT    = 15;
	localparam int unsigned UNC_UNEXP_CPL    = 16;
	localparam int unsigned UNC_RX_OVERFLOW  = 17;
	localparam int unsigned UNC_MALFORMED    = 18;
	localparam int unsigned UNC_E2E_CRC      = 19;
	localparam int unsigned UNC_UNSUP_REQ    = 20;
	localparam logic [31:0] UNC_IMPL         = 32'h001F_F011;

	// Product data engine states.
	typedef enum logic [1:0] {
		VMAC_VPD_IDLE  = 2'b00,
		VMAC_VPD_READ  = 2'b01,
		VMAC_VPD_WRITE = 2'b10
	} vmac_vpd_state_e;

	// Expands four byte enables into a 32-bit lane mask.
	function automatic logic [31:0] vmac_be_mask(input logic [3:0] be);
		vmac_be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

endpackage

// *** core/vmac_err_if.sv ***
// Purpose: Carries register writes and sticky state between bank and error block.
// Assumes: Single clock domain.
// Notes: The register side drives write data, the error block returns state.
`timescale 1ns/1ps
`default_nettype none

interface vmac_err_if;
	logic [31:0] wdata;
	logic [3:0]  be;
	logic        status_wr;
	logic        mask_wr;
	logic [31:0] status;
	logic [31:0] mask;

	modport bank (input wdata, be, status_wr, mask_wr, output status, mask);
	modport regs (output wdata, be, status_wr, mask_wr, input status, mask);
endinterface

`default_nettype wire

// *** core/vmac_unc_err_bank.sv ***
// Purpose: Sticky uncorrectable error status and mask with first-error log.
// Assumes: Error events are one-cycle pulses on the core clock.
// Notes: Only the power-on reset touches this state.
`timescale 1ns/1ps
`default_nettype none

module vmac_unc_err_bank (
	input  wire logic                            sys_clk_i,
	input  wire logic                            rstn_i,
	vmac_err_if.bank                             err_if,
	input  wire logic [vmac_pkg::UNC_W-1:0]      err_event_i,
	output logic                                 err_report_o,
	output logic [vmac_pkg::FIRST_PTR_W-1:0]     first_err_ptr_o,
	output logic                                 first_err_valid_o
);
	import vmac_pkg::*;

	logic [31:0]            status;
	logic [31:0]            mask;
	logic [31:0]            next_status;
	logic [31:0]            next_mask;
	logic [31:0]            event_vec;
	logic [31:0]            lane;
	logic [31:0]            unmasked;
	logic [FIRST_PTR_W-1:0] lowest;
	logic                   logged;

	assign event_vec = {{(32 - UNC_W){1'b0}}, err_event_i};
	assign lane      = vmac_be_mask(err_if.be);
	assign unmasked  = event_vec & ~mask & UNC_IMPL; // [RULE19]

	// Per-bit next values; an event in the clearing cycle keeps its flag.
	for (genvar i = 0; i < 32; i++) begin : g_bit
		if (UNC_IMPL[i]) begin : g_impl
			assign next_status[i] = event_vec[i] |
				(status[i] & ~(err_if.status_wr & lane[i] & err_if.wdata[i])); // [RULE17]
			assign next_mask[i] = (err_if.mask_wr & lane[i]) ? err_if.wdata[i] : mask[i]; // [RULE18]
		end else begin : g_rsvd
			assign next_status[i] = 1'b0;
			assign next_mask[i]   = 1'b0;
		end
	end

	// Sticky state: only the power-on reset clears it.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			status <= '0; // [RULE20]
			mask   <= '0;
		end else begin
			status <= next_status;
			mask   <= next_mask;
		end
	end

	// Lowest unmasked event in this cycle wins the first-error slot.
	always_comb begin
		lowest = '0;
		for (int k = 31; k >= 0; k--) begin
			if (unmasked[k]) begin
				lowest = k[FIRST_PTR_W-1:0];
			end
		end
	end

	// First-error log refills once the logged flag has been cleared.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			logged          <= 1'b0;
			first_err_ptr_o <= '0;
		end else if ((|unmasked) && (!logged || !status[first_err_ptr_o])) begin
			logged          <= 1'b1; // [RULE19]
			first_err_ptr_o <= lowest;
		end
	end

	// Masked errors are recorded but never reported.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			err_report_o <= 1'b0;
		end else begin
			err_report_o <= |unmasked; // [RULE19]
		end
	end

	assign first_err_valid_o = logged & status[first_err_ptr_o];
	assign err_if.status     = status;
	assign err_if.mask       = mask;

endmodule // vmac_unc_err_bank

`default_nettype wire

// *** core/vmac_config_regs.sv ***
// Purpose: Configuration registers for product data, message interrupts and errors.
// Assumes: One request at a time; answer one cycle after the request.
// Notes: Hot reset clears ordinary registers; sticky error state survives it.
`timescale 1ns/1ps
`default_nettype none

module vmac_config_regs (
	input  wire logic                            sys_clk_i,
	input  wire logic                            rstn_i,
	input  wire logic                            hot_reset_i,
	input  wire logic                            cfg_req_i,
	input  wire logic                            cfg_we_i,
	input  wire logic [vmac_pkg::ADDR_W-1:0]     cfg_addr_i,
	input  wire logic [3:0]                      cfg_be_i,
	input  wire logic [31:0]                     cfg_wdata_i,
	output logic                                 cfg_ack_o,
	output logic [31:0]                          cfg_rdata_o,
	output logic                                 eeprom_req_o,
	output logic                                 eeprom_we_o,
	output logic [7:0]                           eeprom_addr_o,
	output logic [31:0]                          eeprom_wdata_o,
	input  wire logic [31:0]                     eeprom_rdata_i,
	input  wire logic                            eeprom_done_i,
	input  wire logic [3:0]                      intx_pin_i,
	output logic [3:0]                           intx_fwd_o,
	output logic                                 msi_enable_o,
	output logic [2:0]                           msi_alloc_count_o,
	output logic [63:0]                          msi_addr_o,
	output logic [15:0]                          msi_data_o,
	input  wire logic [vmac_pkg::UNC_W-1:0]      err_event_i,
	output logic                                 err_report_o,
	output logic [vmac_pkg::FIRST_PTR_W-1:0]     first_err_ptr_o,
	output logic                                 first_err_valid_o
);
	import vmac_pkg::*;

	vmac_err_if err_if ();

	vmac_vpd_state_e          vpd_state;
	logic [VPD_ADDR_W-1:0]    vpd_addr;
	logic [VPD_ADDR_W-1:0]    next_vpd_addr;
	logic                     vpd_op;
	logic [31:0]              product_data_window;
	logic                     msi_en;
	logic [2:0]               msi_mme;
	logic                     msi_a64;
	logic [31:0]              msi_addr_lo;
	logic [31:0]              msi_addr_hi;
	logic [31:0]              msi_data;
	logic [3:0]               intx_meta;
	logic [3:0]               intx_sync;
	logic [ADDR_W-1:0]        dw_addr;
	logic [31:0]              lane;
	logic                     wr;
	logic                     vpd_busy;
	logic                     vpd_start;
	logic [31:0]              rd_value;

	// Requests are decoded on the dword address; the two low bits are ignored.
	assign dw_addr  = {cfg_addr_i[ADDR_W-1:2], 2'b00};
	assign lane     = vmac_be_mask(cfg_be_i); // [RULE3]
	assign wr       = cfg_req_i & cfg_we_i;
	assign vpd_busy = (vpd_state != VMAC_VPD_IDLE);

	// A write to the top lane of the control word launches an EEPROM cycle.
	// While one is running, control and data writes are dropped so that the
	// engine never sees its address or payload change under it.
	assign vpd_start     = wr && (dw_addr == OFS_VPD_CTRL) && cfg_be_i[3] && !vpd_busy;
	assign next_vpd_addr = (wr && (dw_addr == OFS_VPD_CTRL) && cfg_be_i[2] && !vpd_busy) ?
		cfg_wdata_i[VPD_ADDR_LSB +: VPD_ADDR_W] : vpd_addr;

	// Product data control word and EEPROM cycle sequencing.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			vpd_state      <= VMAC_VPD_IDLE;
			vpd_addr       <= '0;
			vpd_op         <= 1'b0;
			eeprom_req_o   <= 1'b0;
			eeprom_we_o    <= 1'b0;
			eeprom_addr_o  <= '0;
			eeprom_wdata_o <= '0;
		end else if (hot_reset_i) begin
			vpd_state      <= VMAC_VPD_IDLE;
			vpd_addr       <= '0;
			vpd_op         <= 1'b0;
			eeprom_req_o   <= 1'b0;
			eeprom_we_o    <= 1'b0;
			eeprom_addr_o  <= '0;
			eeprom_wdata_o <= '0;
		end else begin
			eeprom_req_o <= 1'b0;
			vpd_addr     <= next_vpd_addr;
			case (vpd_state)
				VMAC_VPD_IDLE: begin
					if (vpd_start) begin
						vpd_op         <= cfg_wdata_i[VPD_OP_BIT]; // [RULE4]
						eeprom_req_o   <= 1'b1;
						eeprom_we_o    <= cfg_wdata_i[VPD_OP_BIT];
						eeprom_addr_o  <= {2'b00, next_vpd_addr} + VPD_EEPROM_BASE; // [RULE1]
						eeprom_wdata_o <= product_data_window;
						vpd_state      <= cfg_wdata_i[VPD_OP_BIT] ?
							VMAC_VPD_WRITE : VMAC_VPD_READ;
					end
				end
				VMAC_VPD_READ: begin
					if (eeprom_done_i) begin
						vpd_op    <= 1'b1; // [RULE4]
						vpd_state <= VMAC_VPD_IDLE;
					end
				end
				VMAC_VPD_WRITE: begin
					if (eeprom_done_i) begin
						vpd_op    <= 1'b0; // [RULE4]
						vpd_state <= VMAC_VPD_IDLE;
					end
				end
				default: begin
					vpd_state <= VMAC_VPD_IDLE;
				end
			endcase
		end
	end

	// Data window: host bytes land per lane; read data arrives whole from
	// the EEPROM with the byte at the programmed address in the low lane.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			product_data_window <= '0;
		end else if (hot_reset_i) begin
			product_data_window <= '0;
		end else if ((vpd_state == VMAC_VPD_READ) && eeprom_done_i) begin
			product_data_window <= eeprom_rdata_i; // [RULE1] [RULE2]
		end else if (wr && (dw_addr == OFS_PRODUCT_DATA_WINDOW) && !vpd_busy) begin
			product_data_window <= (product_data_window & ~lane) | (cfg_wdata_i & lane); // [RULE3]
		end
	end

	// Message control word: enable and allocated count are host fields.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			msi_en  <= 1'b0;
			msi_mme <= MSI_MME_RESET;
			msi_a64 <= MSI_A64_RESET;
		end else if (hot_reset_i) begin
			msi_en  <= 1'b0;
			msi_mme <= MSI_MME_RESET;
			msi_a64 <= MSI_A64_RESET;
		end else if (wr && (dw_addr == OFS_MSI_CTRL) && cfg_be_i[2]) begin
			msi_en  <= cfg_wdata_i[MSI_EN_BIT]; // [RULE8]
			msi_mme <= cfg_wdata_i[MSI_MME_LSB +: 3]; // [RULE10]
			msi_a64 <= cfg_wdata_i[MSI_A64_BIT];
		end
	end

	// Message address and data words, merged per byte lane.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			msi_addr_lo <= '0;
			msi_addr_hi <= '0;
			msi_data    <= '0;
		end else if (hot_reset_i) begin
			msi_addr_lo <= '0;
			msi_addr_hi <= '0;
			msi_data    <= '0;
		end else if (wr) begin
			if (dw_addr == OFS_MSI_ADDR_LO) begin
				msi_addr_lo <= (msi_addr_lo & ~(lane & MSI_ADDR_WMASK)) |
					(cfg_wdata_i & lane & MSI_ADDR_WMASK); // [RULE11]
			end
			if (dw_addr == OFS_MSI_ADDR_HI) begin
				msi_addr_hi <= (msi_addr_hi & ~lane) | (cfg_wdata_i & lane); // [RULE12]
			end
			if (dw_addr == OFS_MSI_DATA) begin
				msi_data <= (msi_data & ~(lane & MSI_DATA_WMASK)) |
					(cfg_wdata_i & lane & MSI_DATA_WMASK); // [RULE13]
			end
		end
	end

	// Legacy interrupt pins come from outside; two flops before any use.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			intx_meta <= '0;
			intx_sync <= '0;
		end else begin
			intx_meta <= intx_pin_i;
			intx_sync <= intx_meta;
		end
	end

	// Pins are forwarded only while message interrupts are off.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			intx_fwd_o <= '0;
		end else begin
			intx_fwd_o <= msi_en ? 4'h0 : intx_sync; // [RULE8]
		end
	end

	// Error block writes pass straight through the carrier.
	assign err_if.wdata     = cfg_wdata_i;
	assign err_if.be        = cfg_be_i;
	assign err_if.status_wr = wr && (dw_addr == OFS_UNC_STATUS); // [RULE17]
	assign err_if.mask_wr   = wr && (dw_addr == OFS_UNC_MASK); // [RULE18]

	vmac_unc_err_bank u_unc_err_bank (
		.sys_clk_i         (sys_clk_i),
		.rstn_i            (rstn_i), // [RULE20]
		.err_if            (err_if.bank),
		.err_event_i       (err_event_i),
		.err_report_o      (err_report_o),
		.first_err_ptr_o   (first_err_ptr_o),
		.first_err_valid_o (first_err_valid_o)
	);

	// Read multiplexer; unmapped and reserved words read as zero.
	always_comb begin
		rd_value = '0;
		case (dw_addr)
			OFS_VPD_CTRL: begin
				rd_value = {vpd_op, 7'h00, next_vpd_addr, 2'b00, VPD_NEXT_PTR, VPD_CAP_ID};
			end
			OFS_PRODUCT_DATA_WINDOW: begin
				rd_value = product_data_window; // [RULE2]
			end
			OFS_MSI_CTRL: begin
				rd_value = {8'h00, msi_a64, msi_mme, MSI_MMC_VALUE, msi_en,
					MSI_NEXT_PTR, MSI_CAP_ID}; // [RULE6] [RULE7] [RULE9]
			end
			OFS_MSI_ADDR_LO: begin
				rd_value = msi_addr_lo & MSI_ADDR_WMASK; // [RULE11]
			end
			OFS_MSI_ADDR_HI: begin
				rd_value = msi_addr_hi;
			end
			OFS_MSI_DATA: begin
				rd_value = msi_data & MSI_DATA_WMASK; // [RULE13]
			end
			OFS_AER_HDR: begin
				rd_value = {AER_NEXT_OFS, AER_VERSION, AER_CAP_ID}; // [RULE14] [RULE15] [RULE16]
			end
			OFS_UNC_STATUS: begin
				rd_value = err_if.status;
			end
			OFS_UNC_MASK: begin
				rd_value = err_if.mask;
			end
			default: begin
				rd_value = '0; // [RULE5]
			end
		endcase
	end

	// Answer one cycle after each request; read data only for reads.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cfg_ack_o   <= 1'b0;
			cfg_rdata_o <= '0;
		end else begin
			cfg_ack_o <= cfg_req_i;
			if (cfg_req_i && !cfg_we_i) begin
				cfg_rdata_o <= rd_value & lane; // [RULE3]
			end
		end
	end

	// Current programming is published to the interrupt datapath.
	assign msi_enable_o      = msi_en;
	assign msi_alloc_count_o = msi_mme;
	assign msi_addr_o        = {msi_addr_hi, msi_addr_lo & MSI_ADDR_WMASK};
	assign msi_data_o        = msi_data[15:0];

endmodule // vmac_config_regs

`default_nettype wire

// *** verif/vmac_config_regs_props.sv ***
// Purpose: Port-level checks on the configuration register bank.
// Assumes: One clock domain, power-on reset active low.
// Notes: Attached by bind to every instance of the bank.
`timescale 1ns/1ps
`default_nettype none

module vmac_config_regs_props (
	input wire logic        sys_clk_i,
	input wire logic        rstn_i,
	input wire logic        cfg_req_i,
	input wire logic        cfg_we_i,
	input wire logic [11:0] cfg_addr_i,
	input wire logic [3:0]  cfg_be_i,
	input wire logic        cfg_ack_o,
	input wire logic [31:0] cfg_rdata_o,
	input wire logic        eeprom_req_o,
	input wire logic [7:0]  eeprom_addr_o,
	input wire logic [3:0]  intx_fwd_o,
	input wire logic        msi_enable_o,
	input wire logic [63:0] msi_addr_o,
	input wire logic [20:0] err_event_i,
	input wire logic        err_report_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	// Full-width reads, the only ones whose data is fixed by the address alone.
	logic rd_full;
	assign rd_full = cfg_req_i && !cfg_we_i && (cfg_be_i == 4'hF);

	a_ack_one_after: assert property (cfg_req_i |=> cfg_ack_o)
		else $error("no acknowledge one cycle after a request");
	a_ack_has_cause: assert property (cfg_ack_o |-> $past(cfg_req_i))
		else $error("acknowledge without a request");
	a_reserved_zero: assert property (rd_full && cfg_addr_i[11:4] == 8'h0E |=>
		cfg_rdata_o == 32'h0) else $error("reserved range read nonzero");
	a_msi_header: assert property (rd_full && cfg_addr_i[11:2] == 10'h03C |=>
		{cfg_rdata_o[19:17], cfg_rdata_o[15:0]} == 19'h00005) else $error("interrupt header wrong");
	a_aer_header: assert property (rd_full && cfg_addr_i[11:2] == 10'h040 |=>
		cfg_rdata_o == 32'h1501_0001) else $error("error header wrong");
	a_intx_blocked: assert property (msi_enable_o && $past(msi_enable_o) |->
		intx_fwd_o == 4'h0) else $error("legacy pins forwarded while enabled");
	a_msi_aligned: assert property (msi_addr_o[1:0] == 2'b00)
		else $error("message address not dword aligned");
	a_eeprom_base: assert property (eeprom_req_o |-> eeprom_addr_o[7:6] == 2'b01)
		else $error("eeprom address lacks base offset");
	a_eeprom_pulse: assert property (eeprom_req_o |=> !eeprom_req_o)
		else $error("eeprom start longer than one cycle");
	a_report_cause: assert property (err_report_o |-> $past(err_event_i) != 21'h0)
		else $error("error report without an event");
endmodule // vmac_config_regs_props

bind vmac_config_regs vmac_config_regs_props vmac_config_regs_props_inst (.sys_clk_i, .rstn_i,
	.cfg_req_i, .cfg_we_i, .cfg_addr_i, .cfg_be_i, .cfg_ack_o, .cfg_rdata_o, .eeprom_req_o,
	.eeprom_addr_o, .intx_fwd_o, .msi_enable_o, .msi_addr_o, .err_event_i, .err_report_o);

`default_nettype wire

// *** verif/vmac_eeprom_model.sv ***
// Purpose: Behavioural EEPROM access engine facing the bank.
// Assumes: Starts are one-cycle pulses; one cycle outstanding.
// Notes: Latency comes from lat_i so the bench can answer fast or slow.
`timescale 1ns/1ps
`default_nettype none

module vmac_eeprom_model (
	input  wire logic        sys_clk_i,
	input  wire logic        rstn_i,
	input  wire logic        req_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic [7:0]  lat_i,
	output var  logic [31:0] rdata_o,
	output var  logic        done_o
);
	logic [7:0] mem [256];
	logic [7:0] cnt;
	logic [7:0] pat;

	// Contents are a fixed pattern the bench can recompute.
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
	end

	// Read data outside a done pulse toggles, so a stale sample shows up.
	always @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt <= 8'h0;
			pat <= 8'h0;
			done_o <= 1'b0;
			rdata_o <= 32'h0;
		end else begin
			pat <= pat + 8'h1;
			rdata_o <= {4{~pat}};
			done_o <= 1'b0;
			if (cnt != 8'h0) begin
				cnt <= cnt - 8'h1;
				if (cnt == 8'h1) begin
					done_o <= 1'b1;
					if (we_i) begin
						for (int k = 0; k < 4; k++) mem[addr_i + 8'(k)] <= wdata_i[8*k +: 8];
					end else begin
						rdata_o <= {mem[addr_i + 8'h3], mem[addr_i + 8'h2],
							mem[addr_i + 8'h1], mem[addr_i]};
					end
				end
			end else if (req_i) begin
				cnt <= lat_i;
			end
		end
	end
endmodule // vmac_eeprom_model

`default_nettype wire

// *** verif/vmac_config_regs_test.sv ***
// Purpose: Self-checking bench for the configuration register bank.
// Assumes: Requests one at a time; answer one cycle after the request.
// Notes: The eeprom model answers with a latency set per test.
`timescale 1ns/1ps
`default_nettype none

module vmac_config_regs_test;
	logic        clk, rstn, hot, req, we, ack, e_req, e_we, e_done, m_en, rep, fvalid;
	logic [11:0] addr;
	logic [3:0]  be, intx, fwd;
	logic [31:0] wd, rd_q, e_wd, e_rd, rdat;
	logic [7:0]  e_addr, lat;
	logic [2:0]  m_cnt;
	logic [63:0] m_addr;
	logic [15:0] m_data;
	logic [20:0] ev;
	logic [4:0]  fptr;
	int          errors = 0;
	int          compares = 0;
	int unsigned pos [11] = '{0, 4, 12, 13, 14, 15, 16, 17, 18, 19, 20};

	vmac_config_regs vmac_config_regs_inst (.sys_clk_i(clk), .rstn_i(rstn), .hot_reset_i(hot),
		.cfg_req_i(req), .cfg_we_i(we), .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wd),
		.cfg_ack_o(ack), .cfg_rdata_o(rd_q), .eeprom_req_o(e_req), .eeprom_we_o(e_we),
		.eeprom_addr_o(e_addr), .eeprom_wdata_o(e_wd), .eeprom_rdata_i(e_rd),
		.eeprom_done_i(e_done), .intx_pin_i(intx), .intx_fwd_o(fwd), .msi_enable_o(m_en),
		.msi_alloc_count_o(m_cnt), .msi_addr_o(m_addr), .msi_data_o(m_data),
		.err_event_i(ev), .err_report_o(rep), .first_err_ptr_o(fptr),
		.first_err_valid_o(fvalid));
	vmac_eeprom_model vmac_eeprom_model_inst (.sys_clk_i(clk), .rstn_i(rstn), .req_i(e_req),
		.we_i(e_we), .addr_i(e_addr), .wdata_i(e_wd), .lat_i(lat), .rdata_o(e_rd),
		.done_o(e_done));

	// Clock of 20 ns period.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask

	// One request, held for one edge; the answer is taken in the ack cycle.
	task automatic acc(input logic w, input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
		@(posedge clk);
		#1 {req, we, addr, be, wd} = {1'b1, w, a, b, d};
		@(posedge clk);
		#1 req = 1'b0;
		rdat = rd_q;
		chk("ack", ack, 1'b1);
	endtask

	task automatic rchk(input logic [11:0] a, input logic [3:0] b, input logic [31:0] e);
		acc(1'b0, a, b, 32'h0);
		chk("read", rdat, e);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Polls the operation bit; a bounded count keeps a stuck engine from hanging the run.
	task automatic vpd_wait(input logic b);
		for (int i = 0; i < 40; i++) begin
			acc(1'b0, 12'h0D8, 4'hF, 32'h0);
			if (rdat[31] === b) break;
		end
		chk("vpd op", rdat[31], b);
	endtask

	function automatic logic [31:0] ew(input logic [7:0] a);
		return {a + 8'h3, a + 8'h2, a + 8'h1, a} ^ 32'hA5A5_A5A5;
	endfunction

	task automatic tally_and_finish;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// Watchdog sized well above the expected run length.
	initial begin
		#400000;
		errors++;
		tally_and_finish;
	end

	// Main sequence.
	initial begin
		{rstn, hot, req, we, addr, be, wd, intx, ev} = '0;
		lat = 8'h6;
		tick(2);
		rstn = 1'b1;
		rchk(12'h0F0, 4'hF, 32'h0080_0005);
		rchk(12'h100, 4'hF, 32'h1501_0001);
		for (int a = 12'h0E0; a <= 12'h0EC; a += 4) begin
			acc(1'b1, 12'(a), 4'hF, 32'hFFFF_FFFF);
			rchk(12'(a), 4'hF, 32'h0);
		end
		$display("test reset_and_reserved done");
		acc(1'b1, 12'h0F0, 4'hF, 32'hFF5F_FFFF); // Allocated count 101, a legal code.
		rchk(12'h0F0, 4'hF, 32'h0051_0005);
		chk("alloc", m_cnt, 3'h5);
		chk("msi en", m_en, 1'b1);
		for (int a = 12'h0F4; a <= 12'h0FC; a += 4) acc(1'b1, 12'(a), 4'hF, 32'hFFFF_FFFF);
		acc(1'b1, 12'h0F8, 4'h3, 32'h0);
		rchk(12'h0F4, 4'hF, 32'hFFFF_FFFC);
		rchk(12'h0F8, 4'hF, 32'hFFFF_0000);
		rchk(12'h0FC, 4'hF, 32'h0000_FFFF);
		chk("maddr", m_addr, 64'hFFFF_0000_FFFF_FFFC);
		chk("mdata", m_data, 16'hFFFF);
		intx = 4'hA;
		tick(4);
		chk("intx off", fwd, 4'h0);
		acc(1'b1, 12'h0F0, 4'h4, 32'h0);
		tick(4);
		chk("intx on", fwd, 4'hA);
		chk("msi off", m_en, 1'b0);
		$display("test message_interrupt done");
		acc(1'b1, 12'h0D8, 4'hC, 32'h0014_0000);
		acc(1'b1, 12'h0DC, 4'hF, 32'hFFFF_FFFF); // Ignored while the slow read runs.
		vpd_wait(1'b1);
		chk("e addr", e_addr, 8'h45);
		rchk(12'h0DC, 4'hF, ew(8'h45));
		rchk(12'h0DC, 4'h2, ew(8'h45) & 32'h0000_FF00);
		lat = 8'h1;
		acc(1'b1, 12'h0DC, 4'hF, 32'hCAFE_F00D);
		acc(1'b1, 12'h0DC, 4'h1, 32'h0000_0011);
		acc(1'b1, 12'h0D8, 4'hC, 32'h8014_0000);
		vpd_wait(1'b0);
		chk("e we", e_we, 1'b1);
		chk("e wdata", e_wd, 32'hCAFE_F011);
		acc(1'b1, 12'h0D8, 4'hC, 32'h0014_0000);
		vpd_wait(1'b1);
		rchk(12'h0DC, 4'hF, 32'hCAFE_F011);
		$display("test product_data done");
		foreach (pos[i]) begin
			#0 ev = 21'h1 << pos[i];
			tick(1);
			ev = 21'h0;
			chk("report", rep, 1'b1);
			chk("first ptr", fptr, 5'(pos[i]));
			chk("first valid", fvalid, 1'b1);
			rchk(12'h104, 4'hF, 32'h1 << pos[i]);
			acc(1'b1, 12'h104, 4'hF, 32'h1 << pos[i]);
			rchk(12'h104, 4'hF, 32'h0);
		end
		acc(1'b1, 12'h108, 4'hF, 32'hFFFF_FFFF);
		rchk(12'h108, 4'hF, 32'h001F_F011);
		ev = 21'h10;
		tick(1);
		ev = 21'h0;
		chk("masked report", rep, 1'b0);
		chk("masked log", fvalid, 1'b0);
		rchk(12'h104, 4'hF, 32'h10);
		hot = 1'b1;
		tick(1);
		hot = 1'b0;
		rchk(12'h104, 4'hF, 32'h10);
		rchk(12'h108, 4'hF, 32'h001F_F011);
		rchk(12'h0F0, 4'hF, 32'h0080_0005);
		rstn = 1'b0;
		tick(2);
		rstn = 1'b1;
		rchk(12'h104, 4'hF, 32'h0);
		rchk(12'h108, 4'hF, 32'h0);
		$display("test error_flags done");
		tally_and_finish;
	end
endmodule // vmac_config_regs_test

`default_nettype wire
